//--- core/fid_decoder.sv
// Coprocessor instruction decoder with AXI4-Lite register access
// Summary of operation
// - Code 00000 adds both sources into the destination.
// - 00001 subtracts second from first, 00011 first from second, into destination.
// - 00010 subtracts only to update status, destination untouched.
// - 00100 abs of sum, 00101 abs of difference, 01011 difference of absolutes.
// - 00110 loads and 00111 saves multiple registers via the host.
// - 01000 multiply, 01001 divide, 01010 reciprocal; 01100 reserved.
// - 01101 and 01110 copy a run of registers from either source.
// - 01111 and 11111 turn the second-source field into a sub-opcode.
// - 10000 compares against a window, 10001 against a volume with Z flags.
// - Codes 10010 to 11110 start the internal graphics routines.
// - Unary 0000 copy, 0001 ones complement, 0010 absolute, 0011 negate.
// - Unary 0100 to 0110 convert formats, source format from type and size.
// - Unary 0111 scale, 1000 square, 1001 root, 1010 root of absolute.
// - Unary 1011 aborts, 1100 sets up vertex check, 1101 reports completion.
// - Unary 1110 and 1111 move memory both ways at the memory-side address.
// - Vector 0000 to 1000: polynomial, MAC, min/max, matrix row multiply, add.
// - Vector 1001 to 1111: add, subtract, dot, cross, magnitude, normalise, reflect.
// - A user routine ends by jumping to internal 0FFFh or returning; then idle.
// - External words split into action, sources, destination, select, operation.
// - Operands from registers, feedback or local bus; bus only for 32-bit.
// - Three continue actions drive write and address latch strobes.
// - External options: absolute, negate, wrap; chained multiply and add.
// - External latency follows the pipeline stage configuration bits.
// - Addressing mode external jumps to twice the function code.
// - Type and size: 00 integer, 10 single, 11 double, 01 reserved.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fid_decoder (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [5:0] o_op_id,
	output logic o_dest_we,
	output logic o_status_upd,
	output logic o_busy,
	output logic o_write_strobe,
	output logic o_address_latch_strobe
);
	import fid_pkg::*;

	// ==========================================================
	// Bus slave
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic w_fire, full_word, cop_issue, ext_issue, cfg_wr, accept_cop;

	fid_state_t state, next_state;
	logic [7:0] cnt, next_cnt;
	logic [3:0] cfg, next_cfg;
	logic [31:0] cop_word, next_cop_word, ext_word, next_ext_word;
	logic [5:0] op_id, next_op_id;
	logic dest_we, next_dest_we, stat_upd, next_stat_upd;
	logic rsvd, next_rsvd, done_flag, next_done_flag;
	logic bus_err, next_bus_err, we_stb, next_we_stb, als_stb, next_als_stb;
	logic [11:0] jump_addr, next_jump_addr;

	// Write path takes address and data in the same handshake
	assign w_fire = awready & wready;
	assign full_word = (i_wstrb == 4'hF);
	// Only abort may interrupt work in progress; others get an error response unless idle
	assign accept_cop = (state == FID_IDLE)
		| ((i_wdata[FID_FN_LSB +: 5] == FID_FN_UNARY)
		& (i_wdata[FID_RB_LSB +: 4] == FID_SUB_ABORT));
	assign cop_issue = w_fire & full_word & (i_awaddr == FID_OFF_COP_INSTR) & accept_cop;
	assign ext_issue = w_fire & full_word & (i_awaddr == FID_OFF_EXT_INSTR)
		& (state == FID_EXTRUN) & (cnt == 8'h00);
	assign cfg_wr = w_fire & (i_awaddr == FID_OFF_CONFIG) & i_wstrb[0];

	always_comb begin
		next_awready = i_awvalid & i_wvalid & ~awready & ~bvalid;
		next_wready = next_awready;
		next_bvalid = bvalid & ~i_bready;
		next_bresp = bresp;
		if (w_fire) begin
			next_bvalid = 1'b1;
			next_bresp = 2'h0;
			if (i_awaddr == FID_OFF_COP_INSTR && !cop_issue)
				next_bresp = 2'h2;
			else if (i_awaddr == FID_OFF_EXT_INSTR && !ext_issue)
				next_bresp = 2'h2;
			else if (i_awaddr != FID_OFF_COP_INSTR && i_awaddr != FID_OFF_EXT_INSTR
				&& i_awaddr != FID_OFF_CONFIG)
				next_bresp = 2'h2;
		end
		next_arready = i_arvalid & ~arready & ~rvalid;
		next_rvalid = rvalid & ~i_rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (arready) begin
			next_rvalid = 1'b1;
			next_rresp = 2'h0;
			case (i_araddr)
				FID_OFF_COP_INSTR: next_rdata = cop_word;
				FID_OFF_EXT_INSTR: next_rdata = ext_word;
				FID_OFF_CONFIG: next_rdata = {28'h0000000, cfg};
				FID_OFF_STATUS: next_rdata = {15'h0000, state, bus_err, rsvd, done_flag,
					stat_upd, dest_we, o_busy, 2'h0, op_id};
				FID_OFF_EXT_FIELDS: next_rdata = ext_word;
				FID_OFF_JUMP_ADDR: next_rdata = {20'h00000, jump_addr};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = 2'h2;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
		end else begin
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// ==========================================================
	// Coprocessor decode
	function automatic logic [5:0] op_index(input logic [4:0] fn, input logic [3:0] sub);
		if (fn == FID_FN_UNARY)
			op_index = {2'h2, sub};
		else if (fn == FID_FN_VECTOR)
			op_index = {2'h3, sub};
		else
			op_index = {1'b0, fn};
	endfunction

	// Fixed pipeline depth: 11 gives one stage, 10 or 01 two, 00 three
	function automatic logic [7:0] stages(input logic [1:0] pipe);
		stages = 8'd1 + {7'h00, ~pipe[0]} + {7'h00, ~pipe[1]};
	endfunction

	logic [4:0] fn;
	logic [3:0] sub;
	logic [1:0] ts;
	logic [5:0] id;
	logic [7:0] lat;
	logic is_ext_jump, routine_end;
	assign fn = i_wdata[FID_FN_LSB +: 5];
	assign sub = i_wdata[FID_RB_LSB +: 4];
	assign ts = {i_wdata[FID_TYPE_BIT], i_wdata[FID_SIZE_BIT]};
	assign id = op_index(fn, sub);
	assign is_ext_jump = (i_wdata[FID_MD_LSB +: 2] == FID_MD_EXT);
	assign routine_end = ext_issue & ((i_wdata[FID_X_ACT_LSB +: 3] == FID_ACT_RETURN)
		| ((i_wdata[FID_X_ACT_LSB +: 3] == FID_ACT_JUMP) & i_wdata[FID_X_INTERNAL_BIT]
		& (i_wdata[11:0] == FID_IDLE_ADDR)));

	always_comb begin
		next_op_id = op_id;
		next_dest_we = dest_we;
		next_stat_upd = stat_upd;
		next_rsvd = rsvd;
		next_cop_word = cop_word;
		next_jump_addr = jump_addr;
		lat = stages(cfg[1:0]);
		if (cop_issue) begin
			next_cop_word = i_wdata;
			next_op_id = id;
			next_rsvd = 1'b0;
			next_dest_we = 1'b0;
			next_stat_upd = 1'b0;
			case (id)
				6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h0B: begin
					next_dest_we = 1'b1;
					next_stat_upd = 1'b1;
				end
				6'h02: next_stat_upd = 1'b1;
				6'h06, 6'h07: next_dest_we = (id == 6'h06);
				6'h08, 6'h09, 6'h0A: begin
					next_dest_we = 1'b1;
					next_stat_upd = 1'b1;
				end
				6'h0D, 6'h0E: next_dest_we = 1'b1;
				6'h10, 6'h11: next_stat_upd = 1'b1;
				6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26: begin
					next_dest_we = 1'b1;
					next_stat_upd = 1'b1;
				end
				6'h27, 6'h28, 6'h29, 6'h2A: begin
					next_dest_we = 1'b1;
					next_stat_upd = 1'b1;
				end
				6'h2B, 6'h2C, 6'h2D: next_stat_upd = 1'b0;
				6'h2E, 6'h2F: next_dest_we = 1'b0;
				6'h0C: next_rsvd = 1'b1;
				default: begin
					next_dest_we = (id >= 6'h12 && id <= 6'h1E) || id[5:4] == 2'h3;
					next_stat_upd = next_dest_we;
				end
			endcase
			if (ts == FID_TS_RSVD) begin
				next_rsvd = 1'b1;
			end
			if (next_rsvd) begin
				next_dest_we = 1'b0;
				next_stat_upd = 1'b0;
			end
			if (is_ext_jump)
				next_jump_addr = {6'h00, fn, 1'b0};
		end
		// Divide and root run long; double multiply costs one extra stage
		if (id == {1'b0, FID_FN_DIV} || id == 6'h29 || id == 6'h2A) begin
			if (ts == FID_TS_SP)
				lat = cfg[1] ? FID_DIV_SP_FAST : FID_DIV_SP_SLOW;
			else if (ts == FID_TS_DP)
				lat = cfg[1] ? FID_DIV_DP_FAST : FID_DIV_DP_SLOW;
			else
				lat = cfg[1] ? FID_DIV_INT_FAST : FID_DIV_INT_SLOW;
		end else if (id == {1'b0, FID_FN_MPY} && ts == FID_TS_DP)
			lat = stages(cfg[1:0]) + 8'd1;
		else if ((id >= 6'h10 && id <= 6'h1E) || id[5:4] == 2'h3)
			lat = FID_ROUTINE_CYC;
	end

	// ==========================================================
	// Sequencer and external instruction fields
	always_comb begin
		next_state = state;
		next_cnt = (cnt != 8'h00) ? cnt - 8'd1 : cnt;
		next_cfg = cfg_wr ? i_wdata[3:0] : cfg;
		next_ext_word = ext_word;
		next_done_flag = done_flag;
		next_bus_err = bus_err;
		next_we_stb = 1'b0;
		next_als_stb = 1'b0;
		case (state)
			FID_IDLE: begin
				if (cop_issue && is_ext_jump)
					next_state = FID_EXTRUN;
				else if (cop_issue && !next_rsvd) begin
					next_state = FID_EXEC;
					next_cnt = lat;
				end
			end
			FID_EXEC: begin
				if (cnt == 8'h01)
					next_state = FID_IDLE;
			end
			FID_EXTRUN: begin
				if (ext_issue) begin
					next_ext_word = i_wdata;
					next_cnt = stages(cfg[1:0]) - 8'd1;
					// Bus operands only reach a 32-bit datapath
					next_bus_err = (i_wdata[FID_X_SEL_LSB +: 4] == FID_SEL_BUS) & cfg[3];
					if (cfg[2]) begin
						next_we_stb = (i_wdata[FID_X_ACT_LSB +: 3] == FID_ACT_CONT_WE)
							| (i_wdata[FID_X_ACT_LSB +: 3] == FID_ACT_CONT_BOTH);
						next_als_stb = (i_wdata[FID_X_ACT_LSB +: 3] == FID_ACT_CONT_ALS)
							| (i_wdata[FID_X_ACT_LSB +: 3] == FID_ACT_CONT_BOTH);
					end
					if (routine_end)
						next_state = FID_IDLE;
				end
			end
			default: next_state = FID_IDLE;
		endcase
		if (cop_issue && id == {2'h2, FID_SUB_CHECK})
			next_done_flag = (state == FID_IDLE);
		if (cop_issue && id == {2'h2, FID_SUB_ABORT}) begin
			next_state = FID_IDLE;
			next_cnt = 8'h00;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= FID_IDLE;
			cnt <= 8'h00;
			cfg <= FID_CONFIG_RST;
			cop_word <= 32'h00000000;
			ext_word <= 32'h00000000;
			op_id <= 6'h00;
			dest_we <= 1'b0;
			stat_upd <= 1'b0;
			rsvd <= 1'b0;
			done_flag <= 1'b0;
			bus_err <= 1'b0;
			we_stb <= 1'b0;
			als_stb <= 1'b0;
			jump_addr <= 12'h000;
			o_busy <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			cfg <= next_cfg;
			cop_word <= next_cop_word;
			ext_word <= next_ext_word;
			op_id <= next_op_id;
			dest_we <= next_dest_we;
			stat_upd <= next_stat_upd;
			rsvd <= next_rsvd;
			done_flag <= next_done_flag;
			bus_err <= next_bus_err;
			we_stb <= next_we_stb;
			als_stb <= next_als_stb;
			jump_addr <= next_jump_addr;
			o_busy <= (next_state != FID_IDLE);
		end
	end

	assign o_awready = awready;
	assign o_wready = wready;
	assign o_bvalid = bvalid;
	assign o_bresp = bresp;
	assign o_arready = arready;
	assign o_rvalid = rvalid;
	assign o_rdata = rdata;
	assign o_rresp = rresp;
	assign o_op_id = op_id;
	assign o_dest_we = dest_we;
	assign o_status_upd = stat_upd;
	assign o_write_strobe = we_stb;
	assign o_address_latch_strobe = als_stb;

	// ==========================================================
	// Checks
	sequence s_cop(logic [4:0] f);
		cop_issue && fn == f && ts != FID_TS_RSVD;
	endsequence
	a_add_writes: assert property (@(posedge i_clk) disable iff (i_rst)
		s_cop(5'h00) |=> o_dest_we && o_status_upd && o_op_id == 6'h00)
		else $error("add does not write destination");
	a_cmp_status_only: assert property (@(posedge i_clk) disable iff (i_rst)
		s_cop(FID_FN_CMP) |=> !o_dest_we && o_status_upd)
		else $error("compare wrote destination");
	a_reserved_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
		cop_issue && fn == FID_FN_RSVD && !is_ext_jump |=> !o_dest_we && !o_status_upd && !o_busy)
		else $error("reserved code had effect");
	a_unary_space: assert property (@(posedge i_clk) disable iff (i_rst)
		s_cop(FID_FN_UNARY) |=> o_op_id[5:4] == 2'h2 && o_op_id[3:0] == $past(sub))
		else $error("unary sub-opcode not taken");
	a_jump_twice: assert property (@(posedge i_clk) disable iff (i_rst)
		cop_issue && is_ext_jump |=> jump_addr == {6'h00, $past(fn), 1'b0} && o_busy)
		else $error("jump address wrong");
	a_one_stage_lat: assert property (@(posedge i_clk) disable iff (i_rst)
		s_cop(5'h00) ##0 (cfg[1:0] == 2'h3 && state == FID_IDLE && !is_ext_jump)
		|=> o_busy ##1 !o_busy)
		else $error("single stage latency wrong");
	a_abort_idles: assert property (@(posedge i_clk) disable iff (i_rst)
		cop_issue && id == {2'h2, FID_SUB_ABORT} |=> state == FID_IDLE && !o_busy)
		else $error("abort did not idle");
	a_routine_end: assert property (@(posedge i_clk) disable iff (i_rst)
		routine_end |=> state == FID_IDLE)
		else $error("routine end not idle");
	a_strobe_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
		o_write_strobe |-> $past(ext_issue) && $past(cfg[2]) ##1 !o_write_strobe)
		else $error("write strobe not a pulse");
	a_reserved_type: assert property (@(posedge i_clk) disable iff (i_rst)
		cop_issue && ts == FID_TS_RSVD |=> !o_dest_we && !o_status_upd)
		else $error("reserved type acted");
endmodule : fid_decoder
`default_nettype wire

//--- core/fid_pkg.sv
// Constants shared by the coprocessor instruction decoder
package fid_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] FID_OFF_COP_INSTR = 8'h00;
	localparam logic [7:0] FID_OFF_EXT_INSTR = 8'h04;
	localparam logic [7:0] FID_OFF_CONFIG = 8'h08;
	localparam logic [7:0] FID_OFF_STATUS = 8'h0C;
	localparam logic [7:0] FID_OFF_EXT_FIELDS = 8'h10;
	localparam logic [7:0] FID_OFF_JUMP_ADDR = 8'h14;
	localparam logic [3:0] FID_CONFIG_RST = 4'h3;
	// ==========================================================
	// Coprocessor instruction fields
	localparam int FID_RA_LSB = 25;
	localparam int FID_RB_LSB = 21;
	localparam int FID_RD_LSB = 16;
	localparam int FID_MD_LSB = 14;
	localparam int FID_FN_LSB = 9;
	localparam int FID_TYPE_BIT = 8;
	localparam int FID_SIZE_BIT = 7;
	localparam logic [1:0] FID_MD_EXT = 2'h3;
	localparam logic [1:0] FID_TS_INT = 2'h0;
	localparam logic [1:0] FID_TS_RSVD = 2'h1;
	localparam logic [1:0] FID_TS_SP = 2'h2;
	localparam logic [1:0] FID_TS_DP = 2'h3;
	// ==========================================================
	// Function codes and sub-opcodes
	localparam logic [4:0] FID_FN_CMP = 5'h02;
	localparam logic [4:0] FID_FN_MPY = 5'h08;
	localparam logic [4:0] FID_FN_DIV = 5'h09;
	localparam logic [4:0] FID_FN_RSVD = 5'h0C;
	localparam logic [4:0] FID_FN_UNARY = 5'h0F;
	localparam logic [4:0] FID_FN_VECTOR = 5'h1F;
	localparam logic [3:0] FID_SUB_ABORT = 4'hB;
	localparam logic [3:0] FID_SUB_CHECK = 4'hD;
	// ==========================================================
	// External instruction fields
	localparam int FID_X_ACT_LSB = 29;
	localparam int FID_X_RA_LSB = 25;
	localparam int FID_X_RB_LSB = 21;
	localparam int FID_X_RD_LSB = 16;
	localparam int FID_X_SEL_LSB = 12;
	localparam int FID_X_INTERNAL_BIT = 16;
	localparam logic [2:0] FID_ACT_CONT = 3'h0;
	localparam logic [2:0] FID_ACT_CONT_WE = 3'h1;
	localparam logic [2:0] FID_ACT_CONT_ALS = 3'h2;
	localparam logic [2:0] FID_ACT_CONT_BOTH = 3'h3;
	localparam logic [2:0] FID_ACT_JUMP = 3'h4;
	localparam logic [2:0] FID_ACT_RETURN = 3'h5;
	localparam logic [3:0] FID_SEL_BUS = 4'hF;
	localparam logic [11:0] FID_IDLE_ADDR = 12'hFFF;
	// ==========================================================
	// Cycle counts
	localparam logic [7:0] FID_DIV_SP_FAST = 8'd8;
	localparam logic [7:0] FID_DIV_DP_FAST = 8'd13;
	localparam logic [7:0] FID_DIV_INT_FAST = 8'd16;
	localparam logic [7:0] FID_DIV_SP_SLOW = 8'd9;
	localparam logic [7:0] FID_DIV_DP_SLOW = 8'd15;
	localparam logic [7:0] FID_DIV_INT_SLOW = 8'd17;
	localparam logic [7:0] FID_ROUTINE_CYC = 8'd16;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		FID_IDLE = 3'b001,
		FID_EXEC = 3'b010,
		FID_EXTRUN = 3'b100
	} fid_state_t;
endpackage : fid_pkg

//--- test/fid_host.sv
// Host model that issues coprocessor instructions over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module fid_host (
	input wire logic i_clk,
	output logic [7:0] o_awaddr,
	output logic o_awvalid,
	input wire logic i_awready,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	output logic o_wvalid,
	input wire logic i_wready,
	input wire logic [1:0] i_bresp,
	input wire logic i_bvalid,
	output logic o_bready,
	output logic [7:0] o_araddr,
	output logic o_arvalid,
	input wire logic i_arready,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	input wire logic i_rvalid,
	output logic o_rready
);
	initial begin
		o_awaddr = 8'h00;
		o_awvalid = 1'b0;
		o_wdata = 32'h0;
		o_wstrb = 4'h0;
		o_wvalid = 1'b0;
		o_bready = 1'b0;
		o_araddr = 8'h00;
		o_arvalid = 1'b0;
		o_rready = 1'b0;
	end
	// ==========================================================
	// Write: address and data together, each released once taken
	task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		logic done;
		done = 1'b0;
		@(posedge i_clk);
		o_awaddr <= a;
		o_wdata <= d;
		o_wstrb <= s;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		while (!done) begin
			@(posedge i_clk);
			if (o_awvalid && i_awready) begin
				o_awvalid <= 1'b0;
				// Released lines flip so stale values cannot pass for good ones
				o_awaddr <= ~a;
			end
			if (o_wvalid && i_wready) begin
				o_wvalid <= 1'b0;
				o_wdata <= ~d;
			end
			if (i_bvalid) begin
				resp = i_bresp;
				o_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : write
	// ==========================================================
	// Read
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic done;
		done = 1'b0;
		@(posedge i_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		while (!done) begin
			@(posedge i_clk);
			if (o_arvalid && i_arready) begin
				o_arvalid <= 1'b0;
				o_araddr <= ~a;
			end
			if (i_rvalid) begin
				d = i_rdata;
				resp = i_rresp;
				o_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : read
endmodule : fid_host
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the coprocessor instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fid_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [5:0] o_op_id;
	logic o_dest_we, o_status_upd, o_busy, o_write_strobe, o_address_latch_strobe;
	int error_cnt = 0;
	int cmp_count = 0;
	int busy_tot = 0;
	int ws_cnt = 0;
	int al_cnt = 0;
	logic [1:0] r;
	logic [31:0] d;
	int t0;
	always #10 i_clk = ~i_clk;
	fid_host host (.i_clk(i_clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
		.o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
		.i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
		.o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
		.i_rvalid(rvalid), .o_rready(rready));
	fid_decoder dut (.i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_op_id(o_op_id),
		.o_dest_we(o_dest_we), .o_status_upd(o_status_upd), .o_busy(o_busy),
		.o_write_strobe(o_write_strobe), .o_address_latch_strobe(o_address_latch_strobe));
	// Busy cycles and strobe pulses are tallied so latency is measured, not guessed
	always @(posedge i_clk) begin
		if (o_busy === 1'b1) busy_tot <= busy_tot + 1;
		if (o_write_strobe === 1'b1) ws_cnt <= ws_cnt + 1;
		if (o_address_latch_strobe === 1'b1) al_cnt <= al_cnt + 1;
	end
	// ==========================================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic issue(input logic [4:0] fn, input logic [3:0] sub, input logic [1:0] md,
		input logic [1:0] ts);
		host.write(FID_OFF_COP_INSTR, {7'h01, sub, 5'h02, md, fn, ts, 7'h20}, 4'hF, r);
	endtask : issue
	task automatic wait_idle(input int lim);
		int n;
		n = 0;
		while (o_busy !== 1'b0 && n < lim) begin
			@(posedge i_clk);
			n++;
		end
		check(32'(o_busy), 32'h0);
	endtask : wait_idle
	task automatic lat(input logic [4:0] fn, input logic [3:0] sub, input logic [1:0] ts,
		input int exp);
		t0 = busy_tot;
		issue(fn, sub, 2'h0, ts);
		wait_idle(60);
		check(32'(busy_tot - t0), 32'(exp));
	endtask : lat
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		check(32'({o_op_id, o_busy, o_dest_we}), 32'h0);
		host.read(FID_OFF_CONFIG, d, r);
		check(d, 32'(FID_CONFIG_RST));
		host.read(8'h18, d, r);
		check({d[29:0], r}, 32'h2);
		host.write(FID_OFF_STATUS, 32'hFFFF, 4'hF, r);
		check(32'(r), 32'h2);
	endtask : t_reset
	task automatic t_codes;
		for (int f = 0; f < 31; f++) begin
			if (f == 15) continue;
			t0 = busy_tot;
			issue(5'(f), 4'h0, 2'h0, FID_TS_SP);
			check(32'({r, o_op_id}), 32'(f));
			if (f inside {0, 1, 3, 4, 5, 8, 9, 10, 11, 13, 14})
				check(32'(o_dest_we), 32'h1);
			if (f == 2) check(32'({o_dest_we, o_status_upd}), 32'h1);
			if (f == 16 || f == 17) check(32'(o_status_upd), 32'h1);
			if (f == 12) check(32'({o_dest_we, o_status_upd, o_busy}), 32'h0);
			wait_idle(60);
			if (f >= 18) check(32'(busy_tot - t0), 32'd16);
		end
	endtask : t_codes
	task automatic t_spaces;
		for (int s = 0; s < 16; s++) begin
			issue(FID_FN_UNARY, 4'(s), 2'h0, FID_TS_SP);
			check(32'(o_op_id), 32'h20 + 32'(s));
			wait_idle(60);
			if (4'(s) == FID_SUB_CHECK) begin
				host.read(FID_OFF_STATUS, d, r);
				check(32'(d[11]), 32'h1);
			end
			lat(FID_FN_VECTOR, 4'(s), FID_TS_SP, 16);
			check(32'(o_op_id), 32'h30 + 32'(s));
		end
		issue(5'h00, 4'h0, 2'h0, FID_TS_RSVD);
		check(32'({o_dest_we, o_status_upd, o_busy}), 32'h0);
		host.read(FID_OFF_STATUS, d, r);
		check(32'(d[12]), 32'h1);
	endtask : t_spaces
	task automatic t_latency;
		for (int c = 0; c < 4; c++) begin
			host.write(FID_OFF_CONFIG, 32'(c), 4'hF, r);
			lat(5'h00, 4'h0, FID_TS_SP, 1 + (c % 2 == 0) + (c < 2));
			lat(FID_FN_DIV, 4'h0, FID_TS_SP, c > 1 ? FID_DIV_SP_FAST : FID_DIV_SP_SLOW);
			lat(FID_FN_DIV, 4'h0, FID_TS_DP, c > 1 ? FID_DIV_DP_FAST : FID_DIV_DP_SLOW);
			lat(FID_FN_DIV, 4'h0, FID_TS_INT, c > 1 ? FID_DIV_INT_FAST : FID_DIV_INT_SLOW);
		end
	endtask : t_latency
	task automatic t_abort;
		issue(FID_FN_DIV, 4'h0, 2'h0, FID_TS_INT);
		issue(FID_FN_MPY, 4'h0, 2'h0, FID_TS_SP);
		check(32'({r, o_op_id}), {24'h0, 2'h2, 1'b0, FID_FN_DIV});
		host.write(FID_OFF_COP_INSTR, 32'h0, 4'h7, r);
		check(32'(r), 32'h2);
		issue(FID_FN_UNARY, FID_SUB_ABORT, 2'h0, FID_TS_SP);
		check(32'(r), 32'h0);
		wait_idle(4);
	endtask : t_abort
	task automatic t_external;
		logic [31:0] w;
		int w0, a0;
		host.write(FID_OFF_CONFIG, 32'h7, 4'hF, r);
		issue(5'd14, 4'h0, FID_MD_EXT, FID_TS_SP);
		check(32'(o_busy), 32'h1);
		host.read(FID_OFF_JUMP_ADDR, d, r);
		check(d, 32'h1C);
		for (int a = 0; a < 4; a++) begin
			w = {3'(a), 4'h5, 4'hA, 5'h13, 4'h2, 12'h9C3};
			w0 = ws_cnt;
			a0 = al_cnt;
			host.write(FID_OFF_EXT_INSTR, w, 4'hF, r);
			@(posedge i_clk);
			check({r, 29'(al_cnt - a0), 1'(ws_cnt - w0)}, 32'(a));
			host.read(FID_OFF_EXT_FIELDS, d, r);
			check(d, w);
		end
		host.write(FID_OFF_CONFIG, 32'hF, 4'hF, r);
		host.write(FID_OFF_EXT_INSTR, {3'h0, 13'h0, FID_SEL_BUS, 12'h001}, 4'hF, r);
		host.read(FID_OFF_STATUS, d, r);
		check(32'(d[13]), 32'h1);
		host.write(FID_OFF_CONFIG, 32'h7, 4'hF, r);
		host.write(FID_OFF_EXT_INSTR, {FID_ACT_JUMP, 12'h0, 1'b1, 4'h0, FID_IDLE_ADDR}, 4'hF, r);
		wait_idle(10);
		issue(5'd3, 4'h0, FID_MD_EXT, FID_TS_SP);
		host.read(FID_OFF_JUMP_ADDR, d, r);
		check(d, 32'h6);
		host.write(FID_OFF_EXT_INSTR, {FID_ACT_RETURN, 29'h0}, 4'hF, r);
		wait_idle(10);
		host.write(FID_OFF_EXT_INSTR, 32'h0, 4'hF, r);
		check(32'(r), 32'h2);
	endtask : t_external
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_reset();
		t_codes();
		t_spaces();
		t_latency();
		t_abort();
		t_external();
		end_sim();
	end
	// Whole run needs well under two thousand cycles; this leaves a wide margin
	initial begin
		#1000000;
		error_cnt++;
		end_sim();
	end
endmodule : tb
`default_nettype wire
